//--- inc/tagprog_pkg.sv
// Constants and types shared by the tag programmer command interpreter.
package tagprog_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_RATE = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int FLASH_TIME_MS = 2000;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_TIME_MS;
   localparam int FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
   localparam int ARRAY_BYTES = 20;
   localparam int ARRAY_BITS = 154;
   localparam logic [4:0] LAST_IDX = 5'd19;
   localparam logic [7:0] DUMMY_MASK = 8'hfc;
   localparam logic [7:0] ARRAY_RESET = 8'hff;
   localparam logic [7:0] CHAR_PROGRAM = 8'h50;
   localparam logic [7:0] CHAR_ERASE = 8'h45;
   localparam logic [7:0] CHAR_READ = 8'h52;
   localparam logic [7:0] CHAR_DOWNLOAD = 8'h44;
   localparam logic [7:0] CHAR_UPLOAD = 8'h55;
   localparam logic [7:0] CHAR_SPACE = 8'h20;
   localparam logic [7:0] CHAR_YES = 8'h59;
   localparam logic [7:0] CHAR_NO = 8'h4e;
   localparam logic [7:0] CHAR_ERROR = 8'h65;
   localparam int BUF_DEPTH = 2;
   typedef enum logic [1:0] {
      OP_ERASE = 2'b00,
      OP_PROGRAM = 2'b01,
      OP_READ = 2'b10
   } tag_op_t;
endpackage

//--- inc/byte_stream_if.sv
// Valid/ready byte stream between the interpreter and its transmit buffer.
`timescale 1ns/100ps
interface byte_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

//--- hdl/byte_buffer.sv
// Small valid/ready FIFO that decouples reply bytes from the serial sender.
`timescale 1ns/100ps
module byte_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   byte_stream_if.sink fill,
   byte_stream_if.source drain
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pop;

   assign fill.ready = (count != CW'(DEPTH));
   assign drain.valid = (count != '0);
   assign drain.data = mem[rd_ptr];

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      push = fill.valid && fill.ready;
      pop = drain.valid && drain.ready;
      next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = CW'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = CW'(count - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage carries no reset; only words counted as present are read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= fill.data;
      end
   end
endmodule

//--- hdl/tag_programmer_command_interpreter.sv
// Serial command interpreter for a contact programmer of a passive tag.
//
// Overview of operation
// - 'P' programs the tag from the array, then replies 'Y' or 'N'.
// - Busy rises when a known command starts and falls when it completes.
// - 'E' erases the tag, then replies 'Y' or 'N'.
// - Erase leaves every tag bit at one; programming clears chosen bits.
// - 'R' reads the tag into the array, then replies 'R'.
// - After 'D', exactly 20 bytes load the array, then busy falls.
// - Each downloaded byte is echoed back to the host.
// - After 'U', a space starts sending the 20 array bytes, then busy falls.
// - The array holds 154 bits in 20 bytes; byte 20 holds bits 152, 153.
// - The six unused bits of byte 20 are ones.
// - The link runs 9600 baud, eight data bits, no parity, one stop bit.
// - Unknown command bytes return 'e' and flash busy for two seconds.
`timescale 1ns/100ps
module tag_programmer_command_interpreter #(
   parameter int BIT_TIME = tagprog_pkg::BIT_CYCLES,
   parameter int FLASH_TIME = tagprog_pkg::FLASH_CYCLES,
   parameter int FLASH_HALF = tagprog_pkg::FLASH_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rx_line,
   output logic tx_line,
   output logic busy,
   output logic tag_start,
   output tagprog_pkg::tag_op_t tag_op,
   output logic [tagprog_pkg::ARRAY_BITS-1:0] tag_wdata,
   input wire logic tag_done,
   input wire logic tag_ok,
   input wire logic [tagprog_pkg::ARRAY_BITS-1:0] tag_rdata
);
   import tagprog_pkg::*;

   // Receiver: two-stage synchroniser, then mid-bit sampling.
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;
   rx_state_t rx_state, next_rx_state;
   logic rx_meta, rx_sync;
   logic [31:0] rx_cnt, next_rx_cnt;
   logic [2:0] rx_bit, next_rx_bit;
   logic [7:0] rx_shift, next_rx_shift;
   logic rx_valid, next_rx_valid;

   always_comb begin
      next_rx_state = rx_state;
      next_rx_cnt = rx_cnt + 32'd1;
      next_rx_bit = rx_bit;
      next_rx_shift = rx_shift;
      next_rx_valid = 1'b0;
      unique case (rx_state)
         RX_IDLE: begin
            next_rx_cnt = '0;
            if (!rx_sync) begin
               next_rx_state = RX_START;
            end
         end
         RX_START: begin
            if (rx_cnt == 32'(BIT_TIME / 2 - 1)) begin
               next_rx_cnt = '0;
               next_rx_bit = '0;
               next_rx_state = rx_sync ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_cnt == 32'(BIT_TIME - 1)) begin
               next_rx_cnt = '0;
               next_rx_shift = {rx_sync, rx_shift[7:1]};
               next_rx_bit = 3'(rx_bit + 3'd1);
               if (rx_bit == 3'd7) begin
                  next_rx_state = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rx_cnt == 32'(BIT_TIME - 1)) begin
               // A missing stop bit drops the byte as a framing error.
               next_rx_valid = rx_sync;
               next_rx_state = RX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_meta <= rx_line;
         rx_sync <= rx_meta;
         rx_state <= next_rx_state;
         rx_cnt <= next_rx_cnt;
         rx_bit <= next_rx_bit;
         rx_shift <= next_rx_shift;
         rx_valid <= next_rx_valid;
      end
   end

   // Reply bytes pass through a two-entry buffer to the sender.
   byte_stream_if #(.WIDTH(8)) reply_in ();
   byte_stream_if #(.WIDTH(8)) reply_out ();

   byte_buffer #(.WIDTH(8), .DEPTH(BUF_DEPTH)) reply_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .fill(reply_in),
      .drain(reply_out)
   );

   // Transmitter: start bit, eight data bits LSB first, one stop bit.
   logic [9:0] tx_shift, next_tx_shift;
   logic [3:0] tx_left, next_tx_left;
   logic [31:0] tx_cnt, next_tx_cnt;
   logic next_tx_line;

   always_comb begin
      next_tx_shift = tx_shift;
      next_tx_left = tx_left;
      next_tx_cnt = tx_cnt;
      next_tx_line = tx_line;
      reply_out.ready = 1'b0;
      if (tx_left == 4'd0) begin
         next_tx_line = 1'b1;
         if (reply_out.valid) begin
            reply_out.ready = 1'b1;
            next_tx_shift = {1'b1, reply_out.data, 1'b0};
            next_tx_left = 4'd10;
            next_tx_cnt = '0;
         end
      end else if (tx_cnt == 32'd0) begin
         next_tx_line = tx_shift[0];
         next_tx_shift = {1'b1, tx_shift[9:1]};
         next_tx_cnt = 32'd1;
      end else if (tx_cnt == 32'(BIT_TIME - 1)) begin
         next_tx_cnt = '0;
         next_tx_left = 4'(tx_left - 4'd1);
      end else begin
         next_tx_cnt = tx_cnt + 32'd1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_shift <= '1;
         tx_left <= '0;
         tx_cnt <= '0;
         tx_line <= 1'b1;
      end else begin
         tx_shift <= next_tx_shift;
         tx_left <= next_tx_left;
         tx_cnt <= next_tx_cnt;
         tx_line <= next_tx_line;
      end
   end

   // Command engine.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TAG = 3'b001,
      ST_LOAD = 3'b010,
      ST_SPACE = 3'b011,
      ST_SEND = 3'b100,
      ST_REPLY = 3'b101,
      ST_FLASH = 3'b110
   } state_t;
   state_t state, next_state;
   logic [7:0] arr [ARRAY_BYTES];
   logic [7:0] next_arr [ARRAY_BYTES];
   logic [4:0] idx, next_idx;
   logic [7:0] reply, next_reply;
   logic push_valid, next_push_valid;
   logic [7:0] push_data, next_push_data;
   logic next_busy, next_tag_start;
   tag_op_t next_tag_op;
   logic [ARRAY_BITS-1:0] next_tag_wdata;
   logic [31:0] flash_cnt, next_flash_cnt, half_cnt, next_half_cnt;

   assign reply_in.valid = push_valid;
   assign reply_in.data = push_data;

   // Byte i bit j of the array is tag bit 8*i+j.
   function automatic logic [ARRAY_BITS-1:0] pack_bits(
      input logic [7:0] a [ARRAY_BYTES]);
      logic [8*ARRAY_BYTES-1:0] flat;
      flat = '0;
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         flat[8*i +: 8] = a[i];
      end
      pack_bits = flat[ARRAY_BITS-1:0];
   endfunction

   always_comb begin
      logic free;
      free = !push_valid || reply_in.ready;
      next_state = state;
      next_arr = arr;
      next_idx = idx;
      next_reply = reply;
      next_push_valid = free ? 1'b0 : push_valid;
      next_push_data = push_data;
      next_busy = busy;
      next_tag_start = 1'b0;
      next_tag_op = tag_op;
      next_tag_wdata = tag_wdata;
      next_flash_cnt = flash_cnt;
      next_half_cnt = half_cnt;
      unique case (state)
         ST_IDLE: begin
            if (rx_valid) begin
               next_busy = 1'b1;
               next_state = ST_TAG;
               next_idx = '0;
               unique case (rx_shift)
                  CHAR_PROGRAM: begin
                     next_tag_start = 1'b1;
                     next_tag_op = OP_PROGRAM;
                     next_tag_wdata = pack_bits(arr);
                  end
                  CHAR_ERASE: begin
                     next_tag_start = 1'b1;
                     next_tag_op = OP_ERASE;
                     next_tag_wdata = '1;
                  end
                  CHAR_READ: begin
                     next_tag_start = 1'b1;
                     next_tag_op = OP_READ;
                  end
                  CHAR_DOWNLOAD: next_state = ST_LOAD;
                  CHAR_UPLOAD: next_state = ST_SPACE;
                  default: begin
                     next_reply = CHAR_ERROR;
                     next_state = ST_REPLY;
                     next_flash_cnt = '0;
                     next_half_cnt = '0;
                  end
               endcase
            end
         end
         ST_TAG: begin
            // Serial bytes arriving here are dropped.
            if (tag_done) begin
               next_busy = 1'b0;
               next_state = ST_REPLY;
               if (tag_op == OP_READ) begin
                  for (int i = 0; i < ARRAY_BYTES; i++) begin
                     next_arr[i] = 8'(tag_rdata >> (8 * i));
                  end
                  next_arr[LAST_IDX] = {DUMMY_MASK[7:2],
                     tag_rdata[ARRAY_BITS-1:ARRAY_BITS-2]};
                  next_reply = CHAR_READ;
               end else begin
                  next_reply = tag_ok ? CHAR_YES : CHAR_NO;
               end
            end
         end
         ST_LOAD: begin
            if (rx_valid) begin
               next_arr[idx] = (idx == LAST_IDX) ?
                  (rx_shift | DUMMY_MASK) : rx_shift;
               next_push_valid = 1'b1;
               next_push_data = rx_shift;
               next_idx = 5'(idx + 5'd1);
               if (idx == LAST_IDX) begin
                  next_busy = 1'b0;
                  next_state = ST_IDLE;
               end
            end
         end
         ST_SPACE: begin
            if (rx_valid && rx_shift == CHAR_SPACE) begin
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (free) begin
               next_push_valid = 1'b1;
               next_push_data = arr[idx];
               next_idx = 5'(idx + 5'd1);
               if (idx == LAST_IDX) begin
                  next_busy = 1'b0;
                  next_state = ST_IDLE;
               end
            end
         end
         ST_REPLY: begin
            if (free) begin
               next_push_valid = 1'b1;
               next_push_data = reply;
               next_state = (reply == CHAR_ERROR) ? ST_FLASH : ST_IDLE;
            end
         end
         ST_FLASH: begin
            next_flash_cnt = flash_cnt + 32'd1;
            next_half_cnt = half_cnt + 32'd1;
            if (half_cnt == 32'(FLASH_HALF - 1)) begin
               next_half_cnt = '0;
               next_busy = !busy;
            end
            if (flash_cnt == 32'(FLASH_TIME - 1)) begin
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         for (int i = 0; i < ARRAY_BYTES; i++) begin
            arr[i] <= ARRAY_RESET;
         end
         idx <= '0;
         reply <= '0;
         push_valid <= 1'b0;
         push_data <= '0;
         busy <= 1'b0;
         tag_start <= 1'b0;
         tag_op <= OP_ERASE;
         tag_wdata <= '1;
         flash_cnt <= '0;
         half_cnt <= '0;
      end else begin
         state <= next_state;
         arr <= next_arr;
         idx <= next_idx;
         reply <= next_reply;
         push_valid <= next_push_valid;
         push_data <= next_push_data;
         busy <= next_busy;
         tag_start <= next_tag_start;
         tag_op <= next_tag_op;
         tag_wdata <= next_tag_wdata;
         flash_cnt <= next_flash_cnt;
         half_cnt <= next_half_cnt;
      end
   end
endmodule

//--- bench/tag_programmer_command_interpreter_properties.sv
// Port-level assertions for the tag programmer command interpreter.
`timescale 1ns/100ps
module tagprog_checker
   import tagprog_pkg::*;
#(parameter int BIT_TIME = 16) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rx_line,
   input wire logic tx_line,
   input wire logic busy,
   input wire logic tag_start,
   input wire tagprog_pkg::tag_op_t tag_op,
   input wire logic [tagprog_pkg::ARRAY_BITS-1:0] tag_wdata,
   input wire logic tag_done,
   input wire logic tag_ok,
   input wire logic [tagprog_pkg::ARRAY_BITS-1:0] tag_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // The longest legal low stretch is a start bit plus eight zero bits.
   int low_run;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_run <= 0;
      end else begin
         low_run <= tx_line ? 0 : low_run + 1;
      end
   end
   sequence s_hold;
      (busy && !tag_start)[*8];
   endsequence
   property p_start_busy;
      tag_start |-> busy;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("busy low while a tag operation starts");
   property p_start_idle;
      tag_start |-> !$past(busy);
   endproperty
   a_start_idle: assert property (p_start_idle)
      else $error("tag operation started while busy");
   property p_hold;
      tag_start |=> s_hold;
   endproperty
   a_hold: assert property (p_hold)
      else $error("busy dropped or second start during operation");
   property p_erase_ones;
      tag_start && tag_op == OP_ERASE |-> &tag_wdata;
   endproperty
   a_erase_ones: assert property (p_erase_ones)
      else $error("erase data not all ones");
   property p_done_clear;
      tag_done |=> !busy;
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("busy still high after operation end");
   property p_op_stable;
      busy && $past(busy) && !tag_start |-> $stable(tag_op);
   endproperty
   a_op_stable: assert property (p_op_stable)
      else $error("operation code moved while busy");
   // Write data may only move with a program or erase start.
   property p_op_legal;
      $changed(tag_wdata) |-> tag_start && tag_op != OP_READ;
   endproperty
   a_op_legal: assert property (p_op_legal)
      else $error("write data changed without a program or erase start");
   property p_tx_low;
      low_run <= 9 * BIT_TIME;
   endproperty
   a_tx_low: assert property (p_tx_low)
      else $error("serial output low too long");
endmodule
bind tag_programmer_command_interpreter tagprog_checker #(
   .BIT_TIME(BIT_TIME)
) chk_u (
   .clk(clk), .sys_rst(sys_rst), .rx_line(rx_line), .tx_line(tx_line),
   .busy(busy), .tag_start(tag_start), .tag_op(tag_op),
   .tag_wdata(tag_wdata), .tag_done(tag_done), .tag_ok(tag_ok),
   .tag_rdata(tag_rdata)
);

//--- bench/tag_seq_model.sv
// Behavioural tag sequencer answering erase, program and read requests.
`timescale 1ns/100ps
module tag_seq_model
   import tagprog_pkg::*;
#(parameter int DELAY = 400) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tag_start,
   input wire tagprog_pkg::tag_op_t tag_op,
   input wire logic [tagprog_pkg::ARRAY_BITS-1:0] tag_wdata,
   input wire logic fail,
   output logic tag_done,
   output logic tag_ok,
   output logic [tagprog_pkg::ARRAY_BITS-1:0] tag_rdata
);
   logic [ARRAY_BITS-1:0] mem;
   logic [ARRAY_BITS-1:0] wd;
   tag_op_t op;
   int cnt;
   // Off the done pulse the answer lines carry inverted values, so a
   // design sampling them at the wrong moment reads garbage.
   assign tag_ok = tag_done ? !fail : fail;
   assign tag_rdata = tag_done ? mem : ~mem;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 0;
         tag_done <= 1'b0;
         mem <= '1;
      end else begin
         tag_done <= 1'b0;
         if (tag_start) begin
            cnt <= DELAY;
            op <= tag_op;
            wd <= tag_wdata;
         end else if (cnt == 1) begin
            cnt <= 0;
            tag_done <= 1'b1;
            if (op == OP_ERASE) begin
               mem <= '1;
            end else if (op == OP_PROGRAM) begin
               mem <= mem & wd;
            end
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

//--- bench/test_tag_programmer_command_interpreter.sv
// Self-checking bench for the tag programmer command interpreter.
`timescale 1ns/100ps
module test_tag_programmer_command_interpreter;
   import tagprog_pkg::*;
   localparam int BT = 16;
   localparam int FT = 200;
   localparam int FH = 25;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rx_line = 1'b1;
   logic fail = 1'b0;
   logic tx_line, busy, tag_start, tag_done, tag_ok;
   tag_op_t tag_op;
   logic [ARRAY_BITS-1:0] tag_wdata, tag_rdata;
   logic [7:0] rxq[$];
   logic [7:0] pat[20];
   logic [7:0] img[20];
   int n_fail = 0;
   int n_checks = 0;
   tag_programmer_command_interpreter #(
      .BIT_TIME(BT), .FLASH_TIME(FT), .FLASH_HALF(FH)
   ) dut_u (
      .clk(clk), .sys_rst(sys_rst), .rx_line(rx_line), .tx_line(tx_line),
      .busy(busy), .tag_start(tag_start), .tag_op(tag_op),
      .tag_wdata(tag_wdata), .tag_done(tag_done), .tag_ok(tag_ok),
      .tag_rdata(tag_rdata)
   );
   tag_seq_model tag_u (
      .clk(clk), .sys_rst(sys_rst), .tag_start(tag_start),
      .tag_op(tag_op), .tag_wdata(tag_wdata), .fail(fail),
      .tag_done(tag_done), .tag_ok(tag_ok), .tag_rdata(tag_rdata)
   );
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(string what, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic send(logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_line = f[i];
         repeat (BT) @(negedge clk);
      end
   endtask
   // Host-side receiver: samples each reply bit in its middle.
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge clk);
         if (tx_line === 1'b0) begin
            repeat (BT / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BT) @(negedge clk);
               b[i] = tx_line;
            end
            repeat (BT) @(negedge clk);
            rxq.push_back(b);
         end
      end
   end
   task automatic expect_byte(string what, logic [7:0] exp);
      int t;
      logic [7:0] got;
      t = 0;
      got = 'x;
      while (rxq.size() == 0 && t < 4000) begin
         @(negedge clk);
         t++;
      end
      if (rxq.size() != 0) begin
         got = rxq.pop_front();
      end
      chk8(what, exp, got);
   endtask
   task automatic t_upload;
      send(CHAR_UPLOAD);
      send(8'h41);
      chk1("busy upload", 1'b1, busy);
      chk1("no early data", 1'b1, rxq.size() == 0);
      send(CHAR_SPACE);
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         expect_byte("upload", img[i]);
      end
      chk1("busy after upload", 1'b0, busy);
   endtask
   // The stray download byte lands mid-operation and must be dropped.
   task automatic t_tagop(logic [7:0] cmd, logic bad, logic [7:0] rep);
      fail = bad;
      send(cmd);
      chk1("busy op", 1'b1, busy);
      send(CHAR_DOWNLOAD);
      expect_byte("reply", rep);
      chk1("busy after op", 1'b0, busy);
   endtask
   task automatic t_download;
      send(CHAR_DOWNLOAD);
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         send(pat[i]);
         chk1("busy load", i < ARRAY_BYTES - 1, busy);
         expect_byte("echo", pat[i]);
      end
   endtask
   task automatic t_unknown;
      int falls;
      logic prev;
      falls = 0;
      send(8'h5a);
      prev = busy;
      repeat (FT + 40) begin
         @(negedge clk);
         if (prev && !busy) begin
            falls++;
         end
         prev = busy;
      end
      chk8("flash falls", 8'(FT / (2 * FH)), 8'(falls));
      chk1("busy after flash", 1'b0, busy);
      expect_byte("error", CHAR_ERROR);
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #600_000;
      n_fail++;
      complete_run;
   end
   initial begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         img[i] = 8'hff;
         pat[i] = 8'(i * 8'h1d + 8'h07);
      end
      pat[19] = 8'h02;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      chk1("tx idle", 1'b1, tx_line);
      chk1("busy reset", 1'b0, busy);
      t_upload;
      t_tagop(CHAR_ERASE, 1'b0, CHAR_YES);
      t_download;
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         img[i] = pat[i];
      end
      img[19] = pat[19] | 8'hfc;
      t_upload;
      t_tagop(CHAR_PROGRAM, 1'b0, CHAR_YES);
      for (int i = 0; i < ARRAY_BYTES - 1; i++) begin
         chk8("packed byte", img[i], tag_wdata[8*i +: 8]);
      end
      chk8("packed top", img[19], {6'h3f, tag_wdata[ARRAY_BITS-1 -: 2]});
      t_tagop(CHAR_READ, 1'b0, CHAR_READ);
      t_upload;
      t_tagop(CHAR_ERASE, 1'b0, CHAR_YES);
      t_tagop(CHAR_READ, 1'b0, CHAR_READ);
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         img[i] = 8'hff;
      end
      t_upload;
      t_tagop(CHAR_PROGRAM, 1'b1, CHAR_NO);
      t_tagop(CHAR_ERASE, 1'b1, CHAR_NO);
      t_unknown;
      repeat (400) @(negedge clk);
      chk1("quiet line", 1'b1, rxq.size() == 0);
      complete_run;
   end
endmodule
